// File: design/dsrm_pkg.sv
// constants and types of the downstream slot receive mask block
// assumes one system clock and an 8-bit register port

package dsrm_pkg;

  // mask registers, at their printed byte addresses
  localparam logic [7:0] MASK0_OFF    = 8'h65;
  localparam logic [7:0] MASK1_OFF    = 8'h66;
  localparam logic [7:0] MASK2_OFF    = 8'h67;
  localparam logic [7:0] MASK3_OFF    = 8'h68;
  // local registers of this block
  localparam logic [7:0] LCOUNT_OFF   = 8'h40;
  localparam logic [7:0] CONTROL_OFF  = 8'h41;
  localparam logic [7:0] STATUS_OFF   = 8'h42;
  localparam logic [7:0] ACTIVE0_OFF  = 8'h43;
  localparam logic [7:0] FWDCOUNT_OFF = 8'h47;

  localparam int         MASK_REGS    = 4;
  localparam int         MASK_BITS    = 8;
  localparam int         SLOTS        = 32;
  localparam int         SLOT_W       = 5;
  localparam int         COUNT_W      = 6;
  localparam int         DATA_W       = 32;
  localparam int         FIFO_DEPTH   = 8;

  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [5:0] LCOUNT_RESET = 6'h00;

  // control register bits
  localparam int         CTRL_COMMIT_BIT = 0;
  // status register bits
  localparam int         STAT_MODE_BIT   = 0;
  localparam int         STAT_PEND_BIT   = 1;
  localparam int         STAT_FULL_BIT   = 2;
  localparam int         STAT_EMPTY_BIT  = 3;

  typedef enum logic [0:0] {
    DSRM_SEL_MASK  = 1'b0,
    DSRM_SEL_COUNT = 1'b1
  } dsrm_sel_e;

  typedef struct packed {
    logic [SLOT_W-1:0] slot;
    logic [DATA_W-1:0] data;
  } dsrm_slot_word_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dsrm_reg_req_s;

endpackage

// File: design/dsrm_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two and an active-low reset copy with synchronised release

`timescale 1ns/100ps

module dsrm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (PW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (PW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      in_ready  <= next_count != (PW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
    end
  end

  // storage has no reset: only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

// File: design/dsrm_top.sv
// downstream slot receive selection of a subordinate bus node
// assumes the slot stream and register port run on sys_clk
//
// Notes on behaviour
// RULE1: mask bit one takes that downstream slot, zero ignores it.
// RULE2: bit k of a mask register selects slot base plus k.
// RULE3: low nibble of the first mask selects slots three down to zero.
// RULE4: second mask register at 0x66 selects slots 8 to 15.
// RULE5: third mask register at 0x67 selects slots 16 to 23.
// RULE6: fourth mask register at 0x68 selects slots 24 to 31.
// RULE7: with no mask bits set, take the first local-count slots instead.
// RULE8: written masks stay pending until the new-structure commit.
// RULE9: selected slots are forwarded toward the local serial port.
// RULE10: first mask register at 0x65 selects slots 0 to 7.
// RULE11: all mask bits reset to zero, so count fallback rules.

`timescale 1ns/100ps

module dsrm_top #(
  parameter int DATA_W     = dsrm_pkg::DATA_W,
  parameter int FIFO_DEPTH = dsrm_pkg::FIFO_DEPTH
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output      logic [7:0]                  reg_rdata,
  input  wire logic                        slot_valid,
  output      logic                        slot_ready,
  input  wire logic [dsrm_pkg::SLOT_W-1:0] slot_index,
  input  wire logic [DATA_W-1:0]           slot_data,
  output      logic                        tdm_valid,
  input  wire logic                        tdm_ready,
  output      logic [dsrm_pkg::SLOT_W-1:0] tdm_slot,
  output      logic [DATA_W-1:0]           tdm_data
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta;
  logic rst_n;

  // release is synchronised; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port request

  dsrm_pkg::dsrm_reg_req_s req;

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  logic [7:0] mask_rel;
  logic [7:0] act_rel;
  logic       hit_mask;
  logic       hit_active;

  assign mask_rel   = req.addr - dsrm_pkg::MASK0_OFF;
  assign act_rel    = req.addr - dsrm_pkg::ACTIVE0_OFF;
  assign hit_mask   = mask_rel < 8'(dsrm_pkg::MASK_REGS);
  assign hit_active = act_rel < 8'(dsrm_pkg::MASK_REGS);

  ////////////////////////////////////////////////////////////////////////
  // pending masks, as software wrote them

  logic [dsrm_pkg::MASK_REGS-1:0][7:0] pend_mask;

  // RULE10 first mask at 0x65
  // RULE4 RULE5 RULE6 following masks in turn
  // RULE11 masks reset clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < dsrm_pkg::MASK_REGS; i++) begin
        pend_mask[i] <= dsrm_pkg::MASK_RESET;
      end
    end else if (req.wr && hit_mask) begin
      pend_mask[mask_rel[1:0]] <= req.wdata;
    end
  end

  logic [dsrm_pkg::COUNT_W-1:0] pend_count;

  // values above the slot total are clipped, a larger count is meaningless
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_count <= dsrm_pkg::LCOUNT_RESET;
    end else if (req.wr && req.addr == dsrm_pkg::LCOUNT_OFF) begin
      if (req.wdata > 8'(dsrm_pkg::SLOTS)) begin
        pend_count <= dsrm_pkg::COUNT_W'(dsrm_pkg::SLOTS);
      end else begin
        pend_count <= req.wdata[dsrm_pkg::COUNT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // commit of a new structure

  logic commit;

  // RULE8 commit bit acts once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      commit <= 1'b0;
    end else begin
      commit <= req.wr && req.addr == dsrm_pkg::CONTROL_OFF &&
                req.wdata[dsrm_pkg::CTRL_COMMIT_BIT];
    end
  end

  logic [dsrm_pkg::MASK_REGS-1:0][7:0] act_mask;
  logic [dsrm_pkg::COUNT_W-1:0]        act_count;

  // RULE8 apply pending on commit
  // a write in the commit cycle lands in pending and waits for the next
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < dsrm_pkg::MASK_REGS; i++) begin
        act_mask[i] <= dsrm_pkg::MASK_RESET;
      end
      act_count <= dsrm_pkg::LCOUNT_RESET;
    end else if (commit) begin
      act_mask  <= pend_mask;
      act_count <= pend_count;
    end
  end

  logic pending_change;

  assign pending_change = (pend_mask != act_mask) ||
                          (pend_count != act_count);

  ////////////////////////////////////////////////////////////////////////
  // slot selection

  logic [dsrm_pkg::SLOTS-1:0] slot_map;
  dsrm_pkg::dsrm_sel_e        sel_mode;
  logic                       slot_taken;

  // one group per mask register, bit k of group n is slot 8*n+k
  always_comb begin
    slot_map        = '0;
    // RULE2 bit k is slot base plus k
    // RULE3 low nibble slots three to zero
    slot_map[3:0]   = act_mask[0][3:0];
    // RULE10 rest of the first group
    slot_map[7:4]   = act_mask[0][7:4];
    // RULE4 slots 8 to 15
    slot_map[15:8]  = act_mask[1];
    // RULE5 slots 16 to 23
    slot_map[23:16] = act_mask[2];
    // RULE6 slots 24 to 31
    slot_map[31:24] = act_mask[3];
  end

  // RULE7 empty masks fall back to count
  assign sel_mode = (slot_map == '0) ? dsrm_pkg::DSRM_SEL_COUNT
                                     : dsrm_pkg::DSRM_SEL_MASK;

  // RULE1 set bit takes slot
  always_comb begin
    slot_taken = 1'b0;
    unique case (sel_mode)
      dsrm_pkg::DSRM_SEL_MASK: begin
        slot_taken = slot_map[slot_index];
      end
      dsrm_pkg::DSRM_SEL_COUNT: begin
        slot_taken = {1'b0, slot_index} < act_count;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // forwarding buffer

  dsrm_pkg::dsrm_slot_word_s in_word;
  dsrm_pkg::dsrm_slot_word_s out_word;
  logic                      fifo_in_valid;
  logic                      fifo_in_ready;
  logic                      fifo_out_valid;
  logic                      fifo_out_ready;

  assign in_word.slot  = slot_index;
  assign in_word.data  = slot_data;
  assign fifo_in_valid = slot_valid && slot_taken;
  // ignored slots are consumed only while the buffer can take a word too,
  // so the stream order is never broken around a stall
  assign slot_ready    = fifo_in_ready;

  // RULE9 selected slots buffered
  dsrm_fifo #(
    .WIDTH ($bits(dsrm_pkg::dsrm_slot_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (in_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (out_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // serial port output stage

  assign fifo_out_ready = !tdm_valid || tdm_ready;

  // RULE9 forward to serial port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdm_valid <= 1'b0;
    end else if (fifo_out_ready) begin
      tdm_valid <= fifo_out_valid;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdm_slot <= '0;
      tdm_data <= '0;
    end else if (fifo_out_ready && fifo_out_valid) begin
      tdm_slot <= out_word.slot;
      tdm_data <= out_word.data;
    end
  end

  logic [7:0] fwd_count;

  // wraps; software takes differences
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_count <= 8'h00;
    end else if (tdm_valid && tdm_ready) begin
      fwd_count <= fwd_count + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read back

  logic [7:0] status;
  logic [7:0] next_rdata;

  always_comb begin
    status = 8'h00;
    status[dsrm_pkg::STAT_MODE_BIT]  = sel_mode;
    status[dsrm_pkg::STAT_PEND_BIT]  = pending_change;
    status[dsrm_pkg::STAT_FULL_BIT]  = !fifo_in_ready;
    status[dsrm_pkg::STAT_EMPTY_BIT] = !fifo_out_valid;
  end

  // unmapped addresses and the commit register read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (hit_mask) begin
      next_rdata = pend_mask[mask_rel[1:0]];
    end else if (hit_active) begin
      next_rdata = act_mask[act_rel[1:0]];
    end else if (req.addr == dsrm_pkg::LCOUNT_OFF) begin
      next_rdata = 8'(pend_count);
    end else if (req.addr == dsrm_pkg::STATUS_OFF) begin
      next_rdata = status;
    end else if (req.addr == dsrm_pkg::FWDCOUNT_OFF) begin
      next_rdata = fwd_count;
    end
  end

  // data stand for the one cycle after the strobe only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// File: bench/dsrm_sva.sv
// port assertions for the slot receive mask top
// assumes shadow registers mirror every register write exactly
`timescale 1ns/100ps
module dsrm_chk #(
  parameter int DATA_W = 32
) (
  input wire logic              sys_clk,
  input wire logic              reset_n,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              slot_valid,
  input wire logic              slot_ready,
  input wire logic [4:0]        slot_index,
  input wire logic              tdm_valid,
  input wire logic              tdm_ready,
  input wire logic [4:0]        tdm_slot,
  input wire logic [DATA_W-1:0] tdm_data
);
  logic [31:0] pend, act, old;
  logic [5:0]  pcnt, acnt, ocnt;
  logic        cmt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  function automatic logic sel(logic [31:0] m, logic [5:0] c,
                               logic [4:0] s);
    return (m != 0) ? m[s] : ({1'b0, s} < c);
  endfunction
  // old selection kept so words in flight over a commit still pass
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {pend, pcnt, act, acnt, old, ocnt, cmt} <= '0;
    end else begin
      cmt <= reg_wr && reg_addr == dsrm_pkg::CONTROL_OFF && reg_wdata[0];
      if (reg_wr && reg_addr == dsrm_pkg::LCOUNT_OFF)
        pcnt <= (reg_wdata > 8'h20) ? 6'h20 : reg_wdata[5:0];
      for (int n = 0; n < 4; n++)
        if (reg_wr && reg_addr == dsrm_pkg::MASK0_OFF + 8'(n))
          pend[8*n +: 8] <= reg_wdata;
      if (cmt)
        {old, ocnt, act, acnt} <= {act, acnt, pend, pcnt};
    end
  end
  ////////////////////////////////////////
  property p_rd0;
    reg_rd && reg_addr == 8'h65 |=> reg_rdata == $past(pend[7:0]);
  endproperty
  a_rd0: assert property (p_rd0) else $error("mask0 read");
  property p_rd1;
    reg_rd && reg_addr == 8'h66 |=> reg_rdata == $past(pend[15:8]);
  endproperty
  a_rd1: assert property (p_rd1) else $error("mask1 read");
  property p_rd2;
    reg_rd && reg_addr == 8'h67 |=> reg_rdata == $past(pend[23:16]);
  endproperty
  a_rd2: assert property (p_rd2) else $error("mask2 read");
  property p_rd3;
    reg_rd && reg_addr == 8'h68 |=> reg_rdata == $past(pend[31:24]);
  endproperty
  a_rd3: assert property (p_rd3) else $error("mask3 read");
  property p_act;
    reg_rd && reg_addr == 8'h43 |=> reg_rdata == $past(act[7:0]);
  endproperty
  a_act: assert property (p_act) else $error("active read");
  property p_mode;
    reg_rd && reg_addr == 8'h42 |=> reg_rdata[0] == ($past(act) == 0);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bit");
  property p_sel;
    tdm_valid |-> sel(act, acnt, tdm_slot) || sel(old, ocnt, tdm_slot);
  endproperty
  a_sel: assert property (p_sel) else $error("unselected out");
  property p_fwd;
    slot_valid && slot_ready && sel(act, acnt, slot_index)
      |-> ##[2:200] tdm_valid;
  endproperty
  a_fwd: assert property (p_fwd) else $error("slot lost");
  property p_hold;
    tdm_valid && !tdm_ready
      |=> tdm_valid && $stable(tdm_slot) && $stable(tdm_data);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  cover property (tdm_valid && tdm_ready);
  cover property (slot_valid && !slot_ready);
  cover property (cmt);
endmodule
bind dsrm_top dsrm_chk #(.DATA_W(DATA_W)) u_dsrm_chk (.sys_clk, .reset_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .slot_valid,
  .slot_ready, .slot_index, .tdm_valid, .tdm_ready, .tdm_slot, .tdm_data);

// File: bench/dsrm_partner.sv
// far side model: upstream slot source and local serial sink
// assumes the bench sets stall and empties got between runs
`timescale 1ns/100ps
module dsrm_partner (
  input  wire logic        sys_clk,
  input  wire logic        slot_ready,
  input  wire logic        tdm_valid,
  input  wire logic [4:0]  tdm_slot,
  input  wire logic [31:0] tdm_data,
  output      logic        slot_valid,
  output      logic [4:0]  slot_index,
  output      logic [31:0] slot_data,
  output      logic        tdm_ready
);
  logic        stall;
  logic [36:0] got[$];
  initial {slot_valid, slot_index, slot_data, tdm_ready, stall} = '0;
  always @(posedge sys_clk) begin
    tdm_ready <= !stall;
    if (tdm_valid && tdm_ready)
      got.push_back({tdm_slot, tdm_data});
  end
  // released lines show inverted data, never a stale copy
  task automatic send(input int n);
    for (int k = 0; k < n; k++) begin
      slot_valid <= 1'b1;
      slot_index <= 5'(k);
      slot_data <= {27'h2a5a5a5, 5'(k)};
      do @(posedge sys_clk); while (!slot_ready);
    end
    slot_valid <= 1'b0;
    slot_index <= ~slot_index;
    slot_data <= ~slot_data;
  endtask
endmodule

// File: bench/testbench.sv
// self-checking bench for the slot receive mask top
// assumes the partner drives the slot stream and the serial sink
`timescale 1ns/100ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata, rv;
  logic        slot_valid, slot_ready, tdm_valid, tdm_ready;
  logic [4:0]  slot_index, tdm_slot;
  logic [31:0] slot_data, tdm_data;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  dsrm_top u_dsrm_top (.sys_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .slot_valid, .slot_ready, .slot_index,
    .slot_data, .tdm_valid, .tdm_ready, .tdm_slot, .tdm_data);
  dsrm_partner u_dsrm_partner (.sys_clk, .slot_ready, .tdm_valid,
    .tdm_slot, .tdm_data, .slot_valid, .slot_index, .slot_data, .tdm_ready);
  ////////////////////////////////////////
  task automatic chk(input logic [36:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [7:0] a, e, input string what);
    rd(a);
    chk(37'(rv), 37'(e), what);
  endtask
  task automatic commit;
    wr(dsrm_pkg::CONTROL_OFF, 8'h01);
  endtask
  task automatic run(input logic [31:0] m, input logic [5:0] c, int n);
    logic [36:0] w;
    u_dsrm_partner.got.delete();
    u_dsrm_partner.send(n);
    repeat (20) @(posedge sys_clk);
    for (int s = 0; s < n; s++)
      if (m != 0 ? m[s] : s < c) begin
        w = u_dsrm_partner.got.pop_front();
        chk(w, {5'(s), 27'h2a5a5a5, 5'(s)}, "word");
      end
    chk(37'(u_dsrm_partner.got.size()), 37'h0, "extra word");
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    for (int n = 0; n < 4; n++)
      rchk(dsrm_pkg::MASK0_OFF + 8'(n), 8'h00, "mask reset");
    rd(dsrm_pkg::STATUS_OFF);
    chk(37'(rv[0]), 37'h1, "count mode");
    run(32'h0, 6'h00, 32);
    rchk(8'h70, 8'h00, "unmapped");
  endtask
  task automatic t_stage;
    wr(dsrm_pkg::MASK0_OFF, 8'h08);
    rchk(dsrm_pkg::ACTIVE0_OFF, 8'h00, "pending");
    rd(dsrm_pkg::STATUS_OFF);
    chk(37'(rv[dsrm_pkg::STAT_PEND_BIT]), 37'h1, "pend set");
    run(32'h0, 6'h00, 32);
    commit();
    rd(dsrm_pkg::STATUS_OFF);
    chk(37'(rv[dsrm_pkg::STAT_PEND_BIT]), 37'h0, "pend clear");
    run(32'h8, 6'h00, 32);
  endtask
  task automatic t_bitmap;
    for (int n = 0; n < 4; n++) begin
      for (int k = 0; k < 4; k++)
        wr(dsrm_pkg::MASK0_OFF + 8'(k), k == n ? 8'h81 : 8'h00);
      commit();
      rchk(dsrm_pkg::MASK0_OFF + 8'(n), 8'h81, "rw");
      rchk(dsrm_pkg::ACTIVE0_OFF + 8'(n), 8'h81, "active");
      run(32'h81 << (8 * n), 6'h00, 32);
    end
  endtask
  task automatic t_count;
    wr(dsrm_pkg::MASK3_OFF, 8'h00);
    wr(dsrm_pkg::LCOUNT_OFF, 8'h05);
    commit();
    run(32'h0, 6'h05, 32);
    wr(dsrm_pkg::LCOUNT_OFF, 8'h28);
    rchk(dsrm_pkg::LCOUNT_OFF, 8'h20, "count clip");
  endtask
  // sink stalls so the fifo fills and refuses
  task automatic t_fifo;
    wr(dsrm_pkg::MASK0_OFF, 8'hff);
    wr(dsrm_pkg::MASK1_OFF, 8'hff);
    commit();
    u_dsrm_partner.stall <= 1'b1;
    fork
      // twelve taken words overfill the fifo plus the output stage
      run(32'hffff, 6'h00, 12);
      begin
        repeat (30) @(posedge sys_clk);
        rd(dsrm_pkg::STATUS_OFF);
        chk(37'(rv[dsrm_pkg::STAT_FULL_BIT]), 37'h1, "full");
        u_dsrm_partner.stall <= 1'b0;
      end
    join
    rd(dsrm_pkg::STATUS_OFF);
    chk(37'(rv[dsrm_pkg::STAT_EMPTY_BIT]), 37'h1, "empty");
    // 1 + 8 + 5 + 12 words were forwarded over the whole run
    rchk(dsrm_pkg::FWDCOUNT_OFF, 8'h1a, "forwarded");
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_stage();
    t_bitmap();
    t_count();
    t_fifo();
    wrap_up();
  end
endmodule
